// ### rtl/sbsc_pkg.sv
// Shared constants and types for the synchronous burst SRAM cycle control.
// Assumes both ends run from the same clk_sys_i at 40 MHz.
package sbsc_pkg;

  // ==========================================================================
  // Widths and sizes
  localparam int ADDR_W = 20;
  localparam int LANE_W = 9;
  localparam int LANES = 4;
  localparam int DATA_W = 36;
  localparam int CNT_W = 2;
  localparam int BURST_LEN = 4;
  localparam int DEPTH = 1048576;

  // ==========================================================================
  // Reset values and counts
  localparam logic [1:0] CNT_RST = 2'h0;
  localparam logic [1:0] BEAT_LAST = 2'h3;
  localparam logic [ADDR_W-1:0] ADDR_RST = 20'h00000;
  localparam logic [DATA_W-1:0] DATA_RST = 36'h000000000;
  localparam logic [1:0] TURN_CYC = 2'h2;

  // ==========================================================================
  // Operation chosen at each clock edge
  typedef enum logic [1:0] {
    OP_DESEL,
    OP_BEGIN,
    OP_NEXT,
    OP_HOLD
  } sbsc_op_t;

  // Host sequencer states
  typedef enum logic [1:0] {
    HS_IDLE,
    HS_TURN,
    HS_BEAT
  } sbsc_host_state_t;

endpackage

// ### rtl/sbsc_if.sv
// Pin bundle between the SRAM cycle control and its host.
// Assumes both ends share clk_sys_i; the data wire is resolved here.
`timescale 1ns/1ps
interface sbsc_if;
  logic [sbsc_pkg::ADDR_W-1:0] addr;
  logic chip_select_a_n;
  logic chip_select_b_hi;
  logic chip_select_c_n;
  logic processor_addr_strobe_n;
  logic controller_addr_strobe_n;
  logic burst_advance_n;
  logic global_write_n;
  logic byte_write_n;
  logic [sbsc_pkg::LANES-1:0] lane_write_n;
  logic output_enable_n;
  logic burst_order_sel_n;
  logic flow_through_sel_n;
  logic [sbsc_pkg::DATA_W-1:0] dq_host_out;
  logic dq_host_oe;
  logic [sbsc_pkg::DATA_W-1:0] dq_dev_out;
  logic dq_dev_oe;
  logic [sbsc_pkg::DATA_W-1:0] dq;

  // Bus level: the device wins if both ends drive; an undriven bus reads as zero.
  assign dq = dq_dev_oe ? dq_dev_out : (dq_host_oe ? dq_host_out : '0);

  modport dev (
    input addr, chip_select_a_n, chip_select_b_hi, chip_select_c_n,
    input processor_addr_strobe_n, controller_addr_strobe_n, burst_advance_n,
    input global_write_n, byte_write_n, lane_write_n, output_enable_n,
    input burst_order_sel_n, flow_through_sel_n, dq,
    output dq_dev_out, dq_dev_oe
  );

  modport host (
    output addr, chip_select_a_n, chip_select_b_hi, chip_select_c_n,
    output processor_addr_strobe_n, controller_addr_strobe_n, burst_advance_n,
    output global_write_n, byte_write_n, lane_write_n, output_enable_n,
    output burst_order_sel_n, flow_through_sel_n, dq_host_out, dq_host_oe,
    input dq
  );
endinterface

// ### rtl/sbsc_burst_ctr.sv
// Two-bit burst address counter with linear or interleaved order.
// Assumes load and step are never both high in one cycle.
`timescale 1ns/1ps
module sbsc_burst_ctr (
  input wire logic clk_sys_i,
  input wire logic sys_rst_i,
  input wire logic load_i,
  input wire logic [1:0] load_val_i,
  input wire logic step_i,
  input wire logic interleave_i,
  output logic [1:0] low_bits_o
);

  logic [1:0] base_reg;
  logic [1:0] cnt_reg;
  logic [1:0] cnt_sel;

  // ==========================================================================
  // Address of this edge's access
  assign cnt_sel = step_i ? 2'(cnt_reg + 2'h1) : cnt_reg;
  assign low_bits_o = load_i ? load_val_i :
    (interleave_i ? (base_reg ^ cnt_sel) : 2'(base_reg + cnt_sel)); // R17

  // ==========================================================================
  // State; the two-bit count wraps to the start after four addresses.
  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      base_reg <= sbsc_pkg::CNT_RST;
      cnt_reg <= sbsc_pkg::CNT_RST;
    end else if (load_i) begin
      base_reg <= load_val_i;
      cnt_reg <= sbsc_pkg::CNT_RST;
    end else begin
      cnt_reg <= cnt_sel; // R17
    end
  end

endmodule

// ### rtl/sbsc_dev.sv
// Cycle control of a synchronous burst SRAM, with its memory array.
// Assumes all pins are synchronous to clk_sys_i except output enable.
`timescale 1ns/1ps
// Function
// R1: Deselect and float on strobe without enable.
// R2: Enabled begin read at external address.
// R3: Enabled controller strobe with write begins write.
// R4: Strobes high, advance low, read next address.
// R5: Same as continued read but writing.
// R6: Advance high, no write: reread current address.
// R7: Advance high with write: write current address.
// R8: Output enable high cuts drivers immediately.
// R9: Drivers only ever carry read data.
// R10: Dummy reads advance the counter normally.
// R11: Host may switch read to write by dummy reads.
// R12: Host floats outputs before driving write data.
// R13: Host may load a new address every cycle.
// R14: Host may burst using controller strobe only.
// R15: Write when global or byte write low.
// R16: All lanes float during any write.
// R17: Counter runs linear or interleaved, wraps at four.
// R18: Read data flows through or is pipelined.
module sbsc_dev (
  input wire logic clk_sys_i,
  input wire logic sys_rst_i,
  sbsc_if.dev pins,
  output sbsc_pkg::sbsc_op_t op_o,
  output logic op_write_o,
  output logic [sbsc_pkg::ADDR_W-1:0] access_addr_o,
  output logic powered_down_o
);

  // ==========================================================================
  // Pin decode
  logic chip_en;
  logic proc_load;
  logic load;
  logic write_ind;
  logic access_write;
  logic access_read;
  logic begin_burst;
  logic deselect;
  logic step;
  sbsc_pkg::sbsc_op_t op;

  assign chip_en = ~pins.chip_select_a_n & pins.chip_select_b_hi & ~pins.chip_select_c_n;

  // The processor strobe is ignored while the first select is high.
  assign proc_load = ~pins.processor_addr_strobe_n & ~pins.chip_select_a_n;
  assign load = ~pins.controller_addr_strobe_n | proc_load;

  assign deselect = load & ~chip_en; // R1
  assign begin_burst = load & chip_en;

  assign write_ind = ~pins.global_write_n | ~pins.byte_write_n; // R15

  // A processor-strobe start is always a read, whatever the write pins say.
  assign access_write = write_ind & ~proc_load & ~deselect; // R2 R3 R5 R7
  assign access_read = ~write_ind & ~deselect | proc_load & chip_en; // R2 R4 R6

  // Advancing depends on the advance pin and the address strobes, not on output enable.
  assign step = ~load & ~pins.burst_advance_n; // R4 R5 R10

  assign op = deselect ? sbsc_pkg::OP_DESEL :
    (begin_burst ? sbsc_pkg::OP_BEGIN : (step ? sbsc_pkg::OP_NEXT : sbsc_pkg::OP_HOLD)); // R4 R6

  // ==========================================================================
  // Address generation
  logic [sbsc_pkg::ADDR_W-1:2] upper_reg;
  logic [sbsc_pkg::ADDR_W-1:2] upper_sel;
  logic [1:0] low_bits;
  logic [sbsc_pkg::ADDR_W-1:0] eff_addr;
  logic interleave;

  assign interleave = pins.burst_order_sel_n; // R17

  // A new burst takes the external address; otherwise the burst stays
  // within its aligned group of four and the upper bits are held.
  assign upper_sel = begin_burst ? pins.addr[sbsc_pkg::ADDR_W-1:2] : upper_reg; // R2 R3 R6 R7

  sbsc_burst_ctr u_ctr (
    .clk_sys_i(clk_sys_i),
    .sys_rst_i(sys_rst_i),
    .load_i(begin_burst),
    .load_val_i(pins.addr[1:0]),
    .step_i(step),
    .interleave_i(interleave),
    .low_bits_o(low_bits)
  );

  assign eff_addr = {upper_sel, low_bits};

  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      upper_reg <= sbsc_pkg::ADDR_RST[sbsc_pkg::ADDR_W-1:2];
    end else begin
      upper_reg <= upper_sel;
    end
  end

  // ==========================================================================
  // Memory lanes
  logic [sbsc_pkg::LANES-1:0] lane_wr;
  logic [sbsc_pkg::DATA_W-1:0] rd_word;

  genvar g;
  generate
    for (g = 0; g < sbsc_pkg::LANES; g = g + 1) begin : g_lane
      logic [sbsc_pkg::LANE_W-1:0] lane_mem [0:sbsc_pkg::DEPTH-1];

      // Global write covers every lane; byte write only the enabled lanes.
      assign lane_wr[g] = access_write &
        (~pins.global_write_n | ~pins.lane_write_n[g]); // R3 R5 R7 R15

      always_ff @(posedge clk_sys_i) begin
        if (lane_wr[g]) begin
          lane_mem[eff_addr] <= pins.dq[g*sbsc_pkg::LANE_W +: sbsc_pkg::LANE_W]; // R3 R5 R7
        end
      end

      assign rd_word[g*sbsc_pkg::LANE_W +: sbsc_pkg::LANE_W] = lane_mem[eff_addr];
    end
  endgenerate

  // ==========================================================================
  // Read data path
  logic flow_through;
  logic [sbsc_pkg::DATA_W-1:0] stage_reg;
  logic stage_valid_reg;
  logic [sbsc_pkg::DATA_W-1:0] out_reg;
  logic drive_reg;
  logic drive_next;
  logic [sbsc_pkg::DATA_W-1:0] out_next;

  assign flow_through = ~pins.flow_through_sel_n; // R18

  // In pipeline mode the previous cycle's read reaches the pins one edge
  // later, and a write captured on that edge still floats the lanes.
  assign drive_next = flow_through ? access_read :
    (stage_valid_reg & ~access_write); // R9 R16 R18
  assign out_next = flow_through ? rd_word : stage_reg; // R18

  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      stage_valid_reg <= 1'b0;
      drive_reg <= 1'b0;
    end else begin
      stage_valid_reg <= access_read;
      drive_reg <= drive_next; // R9 R16
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      stage_reg <= sbsc_pkg::DATA_RST;
      out_reg <= sbsc_pkg::DATA_RST;
    end else begin
      if (access_read) begin
        stage_reg <= rd_word;
      end
      out_reg <= out_next;
    end
  end

  // Output enable acts without the clock: it can only cut the drivers.
  assign pins.dq_dev_out = out_reg;
  assign pins.dq_dev_oe = drive_reg & ~pins.output_enable_n; // R8 R9

  // ==========================================================================
  // Observation outputs
  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      op_o <= sbsc_pkg::OP_DESEL;
      op_write_o <= 1'b0;
      access_addr_o <= sbsc_pkg::ADDR_RST;
      powered_down_o <= 1'b1;
    end else begin
      op_o <= op;
      op_write_o <= access_write;
      access_addr_o <= eff_addr;
      powered_down_o <= deselect; // R1
    end
  end

endmodule

// ### rtl/sbsc_host.sv
// Host end: turns single or four-beat requests into SRAM pin cycles.
// Assumes the memory answers as the cycle control end does.
`timescale 1ns/1ps
module sbsc_host (
  input wire logic clk_sys_i,
  input wire logic sys_rst_i,
  sbsc_if.host pins,
  input wire logic interleave_i,
  input wire logic pipeline_i,
  input wire logic cmd_valid_i,
  input wire logic cmd_write_i,
  input wire logic cmd_burst_i,
  input wire logic [sbsc_pkg::ADDR_W-1:0] cmd_addr_i,
  input wire logic [sbsc_pkg::LANES-1:0] cmd_lane_en_i,
  input wire logic [sbsc_pkg::BURST_LEN*sbsc_pkg::DATA_W-1:0] cmd_wdata_i,
  output logic cmd_ready_o,
  output logic [sbsc_pkg::DATA_W-1:0] rdata_o,
  output logic rdata_valid_o
);

  sbsc_pkg::sbsc_host_state_t state_reg;
  logic write_reg;
  logic burst_reg;
  logic last_read_reg;
  logic [1:0] beat_reg;
  logic [1:0] turn_reg;
  logic [sbsc_pkg::ADDR_W-1:0] addr_reg;
  logic [sbsc_pkg::LANES-1:0] lane_en_reg;
  logic [sbsc_pkg::BURST_LEN*sbsc_pkg::DATA_W-1:0] wdata_reg;
  logic [2:0] rd_pipe_reg;

  // ==========================================================================
  // Sequencer decode
  logic accept;
  logic need_turn;
  logic issue_first;
  logic issue_more;
  logic issuing;
  logic issue_write;
  logic [1:0] issue_beat;
  logic done;
  logic capture;
  logic [sbsc_pkg::BURST_LEN*sbsc_pkg::DATA_W-1:0] wdata_sel;

  assign accept = (state_reg == sbsc_pkg::HS_IDLE) & cmd_valid_i & cmd_ready_o;
  assign wdata_sel = accept ? cmd_wdata_i : wdata_reg;
  assign need_turn = cmd_write_i & last_read_reg; // R11 R12
  assign issue_first = (accept & ~need_turn) |
    ((state_reg == sbsc_pkg::HS_TURN) & (turn_reg == 2'h0));
  assign issue_more = (state_reg == sbsc_pkg::HS_BEAT);
  assign issuing = issue_first | issue_more;
  assign issue_write = accept ? cmd_write_i : write_reg;
  assign issue_beat = issue_first ? 2'h0 : 2'(beat_reg + 2'h1);
  assign done = issuing & (~(accept ? cmd_burst_i : burst_reg) | issue_beat == sbsc_pkg::BEAT_LAST);
  assign capture = pipeline_i ? rd_pipe_reg[2] : rd_pipe_reg[1]; // R18

  // ==========================================================================
  // Sequencer state
  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      state_reg <= sbsc_pkg::HS_IDLE;
      turn_reg <= 2'h0;
      beat_reg <= 2'h0;
    end else begin
      unique case (state_reg)
        sbsc_pkg::HS_IDLE: begin
          if (accept & need_turn) begin
            state_reg <= sbsc_pkg::HS_TURN;
            turn_reg <= 2'(sbsc_pkg::TURN_CYC - 2'h1);
          end else if (accept & ~done) begin
            state_reg <= sbsc_pkg::HS_BEAT;
          end
        end
        sbsc_pkg::HS_TURN: begin
          turn_reg <= 2'(turn_reg - 2'h1);
          if (issue_first) begin
            state_reg <= done ? sbsc_pkg::HS_IDLE : sbsc_pkg::HS_BEAT;
          end
        end
        sbsc_pkg::HS_BEAT: begin
          if (done) begin
            state_reg <= sbsc_pkg::HS_IDLE;
          end
        end
      endcase
      if (issuing) begin
        beat_reg <= issue_beat;
      end
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      write_reg <= 1'b0;
      burst_reg <= 1'b0;
      addr_reg <= sbsc_pkg::ADDR_RST;
      lane_en_reg <= '0;
      wdata_reg <= '0;
      last_read_reg <= 1'b0;
      cmd_ready_o <= 1'b0;
    end else begin
      if (accept) begin
        write_reg <= cmd_write_i;
        burst_reg <= cmd_burst_i;
        addr_reg <= cmd_addr_i;
        lane_en_reg <= cmd_lane_en_i;
        wdata_reg <= cmd_wdata_i;
      end
      if (issuing) begin
        last_read_reg <= ~issue_write;
      end
      cmd_ready_o <= (state_reg == sbsc_pkg::HS_IDLE) ? ~accept | done : done;
    end
  end

  // ==========================================================================
  // Pins; idle cycles are deselects with the first select high.
  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      pins.addr <= sbsc_pkg::ADDR_RST;
      pins.chip_select_a_n <= 1'b1;
      pins.controller_addr_strobe_n <= 1'b0;
      pins.burst_advance_n <= 1'b1;
      pins.byte_write_n <= 1'b1;
      pins.lane_write_n <= '1;
      pins.output_enable_n <= 1'b1;
      pins.dq_host_out <= sbsc_pkg::DATA_RST;
      pins.dq_host_oe <= 1'b0;
    end else begin
      pins.addr <= accept ? cmd_addr_i : addr_reg;
      pins.chip_select_a_n <= ~issuing;
      pins.controller_addr_strobe_n <= ~(issue_first | ~issuing); // R13 R14
      pins.burst_advance_n <= ~issue_more; // R14
      pins.byte_write_n <= ~(issuing & issue_write);
      pins.lane_write_n <= ~(accept ? cmd_lane_en_i : lane_en_reg);
      pins.output_enable_n <= (state_reg == sbsc_pkg::HS_TURN) | (accept & need_turn) |
        (issuing & issue_write); // R12
      pins.dq_host_out <= wdata_sel[issue_beat*sbsc_pkg::DATA_W +: sbsc_pkg::DATA_W];
      pins.dq_host_oe <= issuing & issue_write; // R12
    end
  end

  // The second and third selects, global write and the unused processor strobe are held constant; order and flow-through straps follow the inputs.
  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      pins.chip_select_b_hi <= 1'b1;
      pins.chip_select_c_n <= 1'b0;
      pins.processor_addr_strobe_n <= 1'b1;
      pins.global_write_n <= 1'b1;
      pins.burst_order_sel_n <= 1'b0;
      pins.flow_through_sel_n <= 1'b1;
    end else begin
      pins.burst_order_sel_n <= interleave_i;
      pins.flow_through_sel_n <= pipeline_i;
    end
  end

  // ==========================================================================
  // Read return
  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      rd_pipe_reg <= 3'h0;
      rdata_o <= sbsc_pkg::DATA_RST;
      rdata_valid_o <= 1'b0;
    end else begin
      rd_pipe_reg <= {rd_pipe_reg[1:0], issuing & ~issue_write};
      rdata_valid_o <= capture;
      if (capture) begin
        rdata_o <= pins.dq;
      end
    end
  end

endmodule

// ### tb/sbsc_sva.sv
// Checker for the pins between the SRAM cycle control and its host.
// Assumes one clock and the synchronous active-high reset of both ends.
`timescale 1ns/1ps
module sbsc_sva (
  input wire logic clk_sys_i,
  input wire logic sys_rst_i,
  input wire logic chip_select_a_n,
  input wire logic chip_select_b_hi,
  input wire logic chip_select_c_n,
  input wire logic processor_addr_strobe_n,
  input wire logic controller_addr_strobe_n,
  input wire logic global_write_n,
  input wire logic byte_write_n,
  input wire logic output_enable_n,
  input wire logic flow_through_sel_n,
  input wire logic dq_dev_oe,
  input wire logic dq_host_oe
);
  default clocking cb @(posedge clk_sys_i);
  endclocking
  default disable iff (sys_rst_i);

  // ==========================================================================
  // Operation decode at the edge
  wire proc_start = !processor_addr_strobe_n && !chip_select_a_n;
  wire load = !controller_addr_strobe_n || proc_start;
  wire enabled = !chip_select_a_n && chip_select_b_hi && !chip_select_c_n;
  wire takes_write = (!global_write_n || !byte_write_n) && !proc_start && (!load || enabled);
  wire rd_begin = load && enabled && !takes_write;

  // ==========================================================================
  // Assertions
  a_oe_cuts_drive: assert property (output_enable_n |-> !dq_dev_oe)
    else $error("device drives while output enable is high");
  a_desel_floats: assert property ((load && !enabled && !flow_through_sel_n) |=> !dq_dev_oe)
    else $error("device drives after a deselect");
  a_write_floats: assert property (takes_write |=> !dq_dev_oe)
    else $error("device drives after a write");
  a_ft_read_drives: assert property ((rd_begin && !flow_through_sel_n) ##1 !output_enable_n |-> dq_dev_oe)
    else $error("flow-through read not driven");
  a_pipe_read_drives: assert property ((rd_begin && flow_through_sel_n) ##1 !takes_write ##1 !output_enable_n
    |-> dq_dev_oe)
    else $error("pipelined read not driven");
  a_no_contention: assert property (!(dq_dev_oe && dq_host_oe))
    else $error("both ends drive the data bus");
  a_host_turn: assert property ($rose(dq_host_oe) |-> !$past(dq_dev_oe))
    else $error("host drives data before the memory released it");
  a_proc_strobe_idle: assert property (processor_addr_strobe_n)
    else $error("host used the processor strobe");

  c_pipe_read: cover property (rd_begin && flow_through_sel_n);
  c_burst_write: cover property (takes_write && !load);
  c_turnaround: cover property ($rose(dq_host_oe));
endmodule

// ### tb/tb_sync_burst_sram_cycle_control.sv
// Testbench: host and cycle control joined, plus a second device driven pin by pin.
// Assumes a 40 MHz clock and a synchronous active-high reset.
`timescale 1ns/1ps
module tb_sync_burst_sram_cycle_control;
  logic clk_sys_i = 1'h0;
  logic sys_rst_i = 1'h1;
  logic interleave = 1'h0;
  logic pipeline = 1'h0;
  logic cmd_valid = 1'h0;
  logic cmd_write = 1'h0;
  logic cmd_burst = 1'h0;
  logic [sbsc_pkg::ADDR_W-1:0] cmd_addr = 20'h00000;
  logic [sbsc_pkg::LANES-1:0] cmd_lane = 4'h0;
  logic [143:0] cmd_wdata = 144'h0;
  logic cmd_ready;
  logic rdata_valid;
  logic [sbsc_pkg::DATA_W-1:0] rdata;
  sbsc_pkg::sbsc_op_t op2;
  logic op_wr2;
  logic pd2;
  logic [sbsc_pkg::ADDR_W-1:0] addr2;
  logic [35:0] mem [logic [19:0]];
  logic [35:0] exp_q [$];
  logic [35:0] d0;
  logic [35:0] d2;
  logic [19:0] a;
  int n_errors = 0;
  int check_count = 0;
  int seed = 77;

  initial begin
    forever #12.5 clk_sys_i = ~clk_sys_i;
  end

  sbsc_if link_if ();
  sbsc_if drv_if ();
  sbsc_dev sbsc_dev_i (.clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i), .pins(link_if), .op_o(), .op_write_o(),
    .access_addr_o(), .powered_down_o());
  sbsc_host sbsc_host_i (.clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i), .pins(link_if), .interleave_i(interleave),
    .pipeline_i(pipeline), .cmd_valid_i(cmd_valid), .cmd_write_i(cmd_write), .cmd_burst_i(cmd_burst),
    .cmd_addr_i(cmd_addr), .cmd_lane_en_i(cmd_lane), .cmd_wdata_i(cmd_wdata), .cmd_ready_o(cmd_ready),
    .rdata_o(rdata), .rdata_valid_o(rdata_valid));
  sbsc_dev sbsc_dev2_i (.clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i), .pins(drv_if), .op_o(op2),
    .op_write_o(op_wr2), .access_addr_o(addr2), .powered_down_o(pd2));
  sbsc_sva sbsc_sva_i (.clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i), .chip_select_a_n(link_if.chip_select_a_n),
    .chip_select_b_hi(link_if.chip_select_b_hi), .chip_select_c_n(link_if.chip_select_c_n),
    .processor_addr_strobe_n(link_if.processor_addr_strobe_n),
    .controller_addr_strobe_n(link_if.controller_addr_strobe_n), .global_write_n(link_if.global_write_n),
    .byte_write_n(link_if.byte_write_n), .output_enable_n(link_if.output_enable_n),
    .flow_through_sel_n(link_if.flow_through_sel_n), .dq_dev_oe(link_if.dq_dev_oe),
    .dq_host_oe(link_if.dq_host_oe));

  // ==========================================================================
  // Checking and closing
  task automatic chk(input string what, input logic [35:0] seen, input logic [35:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic end_of_test();
    $display("errors %0d checks %0d", n_errors, check_count);
    if (n_errors == 0 && check_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // ==========================================================================
  // Reference model of the burst order and the array
  function automatic logic [19:0] beat(input logic [19:0] base, input int k);
    logic [1:0] lo;
    lo = interleave ? (base[1:0] ^ 2'(k)) : (base[1:0] + 2'(k));
    return {base[19:2], lo};
  endfunction

  task automatic host_cmd(input logic wr, input logic burst, input logic [19:0] ad, input logic [3:0] ln);
    logic [19:0] ab;
    int t;
    t = 0;
    do begin
      @(negedge clk_sys_i);
      t++;
    end while (cmd_ready !== 1'h1 && t < 64);
    for (int k = 0; k < 5; k++) begin
      cmd_wdata = {cmd_wdata[111:0], 32'($random(seed))};
    end
    for (int k = 0; k < (burst ? 4 : 1); k++) begin
      ab = beat(ad, k);
      for (int g = 0; g < 4; g++) begin
        if (wr && ln[g]) begin
          mem[ab][9*g +: 9] = cmd_wdata[36*k + 9*g +: 9];
        end
      end
      if (!wr) begin
        exp_q.push_back(mem[ab]);
      end
    end
    cmd_write = wr;
    cmd_burst = burst;
    cmd_addr = ad;
    cmd_lane = ln;
    cmd_valid = 1'h1;
    @(negedge clk_sys_i);
    cmd_valid = 1'h0;
  endtask

  always @(negedge clk_sys_i) begin
    if (!sys_rst_i && rdata_valid === 1'h1) begin
      if (exp_q.size() == 0) begin
        chk("extra rdata", 36'h1, 36'h0);
      end else begin
        chk("rdata", rdata, exp_q.pop_front());
      end
    end
  end

  // ==========================================================================
  // Pin-level driver of the second device
  task automatic step(input logic [6:0] c, input logic [35:0] d, input sbsc_pkg::sbsc_op_t eop,
    input logic ewr, input logic [19:0] ea);
    @(negedge clk_sys_i);
    {drv_if.chip_select_a_n, drv_if.chip_select_c_n, drv_if.processor_addr_strobe_n,
      drv_if.controller_addr_strobe_n, drv_if.burst_advance_n, drv_if.global_write_n, drv_if.output_enable_n} = c;
    drv_if.addr = a;
    drv_if.dq_host_out = d;
    drv_if.dq_host_oe = !c[1];
    @(posedge clk_sys_i);
    #2;
    chk("op", 36'(op2), 36'(eop));
    chk("powered down", 36'(pd2), 36'(eop == sbsc_pkg::OP_DESEL));
    if (eop != sbsc_pkg::OP_DESEL) begin
      chk("op write", 36'(op_wr2), 36'(ewr));
      chk("access addr", 36'(addr2), 36'(ea));
    end
  endtask

  initial begin
    drv_if.chip_select_b_hi = 1'h1;
    drv_if.byte_write_n = 1'h1;
    drv_if.lane_write_n = 4'hf;
    drv_if.burst_order_sel_n = 1'h0;
    drv_if.flow_through_sel_n = 1'h0;
    {drv_if.chip_select_a_n, drv_if.chip_select_c_n, drv_if.processor_addr_strobe_n,
      drv_if.controller_addr_strobe_n, drv_if.burst_advance_n, drv_if.global_write_n, drv_if.output_enable_n} = 7'h56;
    drv_if.addr = 20'h00000;
    drv_if.dq_host_out = 36'h0;
    drv_if.dq_host_oe = 1'h0;
    repeat (16) @(negedge clk_sys_i);
    sys_rst_i = 1'h0;
    // Start at low bits 3 so the first step wraps the counter.
    a = {18'($random(seed)), 2'h3};
    d0 = 36'($random(seed));
    d2 = 36'($random(seed));
    step(7'h0d, d2, sbsc_pkg::OP_BEGIN, 1'h0, a);
    step(7'h15, d0, sbsc_pkg::OP_BEGIN, 1'h1, a);
    step(7'h59, d0, sbsc_pkg::OP_NEXT, 1'h1, {a[19:2], 2'h0});
    step(7'h5d, d2, sbsc_pkg::OP_HOLD, 1'h1, {a[19:2], 2'h0});
    step(7'h16, d0, sbsc_pkg::OP_BEGIN, 1'h0, a);
    chk("ft data", drv_if.dq, d0);
    step(7'h5a, d0, sbsc_pkg::OP_NEXT, 1'h0, {a[19:2], 2'h0});
    chk("next data", drv_if.dq, d2);
    step(7'h5e, d0, sbsc_pkg::OP_HOLD, 1'h0, {a[19:2], 2'h0});
    chk("hold data", drv_if.dq, d2);
    @(negedge clk_sys_i);
    drv_if.output_enable_n = 1'h1;
    #1;
    chk("oe cut", 36'(drv_if.dq_dev_oe), 36'h0);
    step(7'h5b, d0, sbsc_pkg::OP_NEXT, 1'h0, {a[19:2], 2'h1});
    chk("dummy float", 36'(drv_if.dq_dev_oe), 36'h0);
    step(7'h2e, d0, sbsc_pkg::OP_DESEL, 1'h0, a);
    chk("desel float", 36'(drv_if.dq_dev_oe), 36'h0);
    step(7'h56, d0, sbsc_pkg::OP_DESEL, 1'h0, a);
    for (int m = 0; m < 4; m++) begin
      repeat (12) @(negedge clk_sys_i);
      interleave = m[0];
      pipeline = m[1];
      a = 20'($random(seed));
      host_cmd(1'h1, 1'h1, a, 4'hf);
      host_cmd(1'h1, 1'h0, beat(a, 2), 4'($random(seed)));
      host_cmd(1'h0, 1'h1, a, 4'h0);
      host_cmd(1'h0, 1'h0, beat(a, 1), 4'h0);
      host_cmd(1'h0, 1'h0, beat(a, 3), 4'h0);
    end
    repeat (20) @(negedge clk_sys_i);
    chk("reads left", 36'(exp_q.size()), 36'h0);
    end_of_test();
  end

  // The whole run needs well under a thousand cycles; this allows four times that.
  initial begin
    repeat (4000) @(posedge clk_sys_i);
    n_errors++;
    end_of_test();
  end
endmodule
